// [verification/ee_ctl_model.sv]
// Two-wire bus controller model that drives the link for the bench
`timescale 1ns/10ps
module ee_ctl_model
  import ee_pkg::*;
(
  // Clock
  input wire logic clk,
  // Link
  output logic scl,
  output logic sda_m,
  input wire logic sda_w
);
  // ----------------------------------------------------------------
  // Link timing: one quarter of the 320 ns link period
  // ----------------------------------------------------------------
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic qtr();
    repeat (2) @(posedge clk);
  endtask
  task automatic start();
    sda_m <= 1'b1;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_m <= 1'b0;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask
  task automatic stop();
    sda_m <= 1'b0;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_m <= 1'b1;
    qtr();
    qtr();
    qtr();
  endtask
  // Sample well after the rise, far from any device update
  task automatic bit_x(input logic b, output logic r);
    sda_m <= b;
    qtr();
    scl <= 1'b1;
    qtr();
    r = sda_w;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask
  // ninth bit: controller ack or nack on reads
  task automatic xfer(input logic [7:0] d, input logic ak_i, output logic [7:0] r,
                      output logic ak);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(ak_i, ak);
  endtask
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the lock and error-status read block
`timescale 1ns/10ps
module tb_top
  import ee_pkg::*;
();
  localparam logic [2:0] STRAP = 3'h5;
  logic clk, rstn, lock, scl, sda_m, sda_o, sda_oe_n, mem_rd, flag, ak;
  logic [GRP_W-1:0] grp;
  logic [CODE_W-1:0] code;
  logic [CODE_W-1:0] mem [8];
  logic [7:0] rb;
  logic [7:0] exp_q[$];
  logic [31:0] d0, d1;
  logic [14:0] ra;
  wire logic sda_w;
  int miscompares, total_checks, cyc, g;
  // Open drain with pull-up: only a low from either side wins
  assign sda_w = sda_m & (sda_oe_n | sda_o);
  // Array data is only good while the fetch strobe is up, so a late fetch shows
  assign code = mem_rd ? mem[grp[2:0]] : ~mem[grp[2:0]];
  ee_lock_ecc_rd u_ee_lock_ecc_rd (.clk(clk), .rstn(rstn), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .addr_pin_i(STRAP), .lock_i(lock), .mem_rd(mem_rd),
    .mem_grp(grp), .mem_code_i(code), .ecc_error_flag(flag));
  ee_ctl_model u_ee_ctl_model (.clk(clk), .scl(scl), .sda_m(sda_m), .sda_w(sda_w));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // Model and checks
  // ----------------------------------------------------------------
  function automatic logic [CODE_W-1:0] enc(input logic [DATA_W-1:0] d);
    logic [CHK_W-1:0] c;
    int p;
    c = '0;
    p = 2;
    for (int j = 0; j < DATA_W; j++) begin
      p++;
      if ((p & (p - 1)) == 0) begin
        p++;
      end
      for (int k = 0; k < CHK_W; k++) begin
        if (p[k]) begin
          c[k] ^= d[j];
        end
      end
    end
    return {c, d};
  endfunction
  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmp1(input string n, input logic e, input logic s);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic addr_wr(input logic [3:0] dc, input logic [14:0] a);
    u_ee_ctl_model.start();
    u_ee_ctl_model.xfer({dc, STRAP, 1'b0}, 1'b1, rb, ak);
    cmp1("device ack", 1'b0, ak);
    u_ee_ctl_model.xfer({1'b0, a[14:8]}, 1'b1, rb, ak);
    cmp1("addr hi ack", 1'b0, ak);
    u_ee_ctl_model.xfer(a[7:0], 1'b1, rb, ak);
    cmp1("addr lo ack", 1'b0, ak);
  endtask
  // Dummy write, restart, then every byte of exp_q; the last one is nacked
  task automatic rd(input logic [3:0] dc, input logic [14:0] a);
    addr_wr(dc, a);
    u_ee_ctl_model.start();
    u_ee_ctl_model.xfer({dc, STRAP, 1'b1}, 1'b1, rb, ak);
    cmp1("read ack", 1'b0, ak);
    for (int i = 0; i < exp_q.size(); i++) begin
      u_ee_ctl_model.xfer(8'hFF, i == exp_q.size() - 1, rb, ak);
      cmp8("read byte", exp_q[i], rb);
    end
    u_ee_ctl_model.stop();
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    lock = 1'b0;
    void'($urandom(32'hB087));
    for (int i = 0; i < 8; i++) begin
      mem[i] = enc($urandom);
    end
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    for (int lk = 0; lk < 2; lk++) begin
      lock <= lk[0];
      ra = 15'($urandom);
      ra[SEL_HI:SEL_LO] = SEL_LOCK;
      exp_q = {};
      repeat (3) exp_q.push_back(8'(lk << LOCK_FLAG_POSITION));
      rd(DEV_CODE_SPC, ra);
      addr_wr(DEV_CODE_SPC, {4'h0, SEL_SECT, 9'h000});
      u_ee_ctl_model.xfer(8'(lk + 1), 1'b1, rb, ak);
      cmp1("probe ack", lk[0], ak);
      u_ee_ctl_model.start();
      u_ee_ctl_model.stop();
      exp_q = {BYTE_IDLE, BYTE_IDLE};
      rd(DEV_CODE_SPC, {4'h0, SEL_SECT, 9'h000});
      $display("lock test %0d done", lk);
    end
    for (int t = 0; t < 3; t++) begin
      g = $urandom_range(0, 6);
      d0 = $urandom;
      d1 = $urandom;
      mem[g] <= enc(d0) ^ (38'h1 << $urandom_range(0, CODE_W - 1));
      mem[g + 1] <= enc(d1);
      ra = 15'($urandom);
      ra[SEL_HI:SEL_LO] = SEL_ECC;
      exp_q = {};
      for (int i = 0; i < 4; i++) exp_q.push_back(d0[8 * i +: 8]);
      rd(DEV_CODE_MEM, {g[12:0], BYTE_FIRST});
      cmp1("flag after bad group", 1'b1, flag);
      exp_q = {ECC_BYTE_ERR, ECC_BYTE_ERR};
      rd(DEV_CODE_SPC, ra);
      cmp1("flag after status read", 1'b0, flag);
      exp_q = {ECC_BYTE_OK};
      rd(DEV_CODE_SPC, ra);
      exp_q = {};
      for (int i = 0; i < 4; i++) exp_q.push_back(d0[8 * i +: 8]);
      for (int i = 0; i < 4; i++) exp_q.push_back(d1[8 * i +: 8]);
      rd(DEV_CODE_MEM, {g[12:0], BYTE_FIRST});
      cmp1("flag after clean group", 1'b0, flag);
      exp_q = {ECC_BYTE_OK};
      rd(DEV_CODE_SPC, ra);
      $display("error flag test %0d done", t);
    end
    results();
  end
endmodule

// [verilog/ee_ecc.sv]
// Single-bit corrector for one four-byte group
`timescale 1ns/10ps
module ee_ecc
  import ee_pkg::*;
(
  // Stored group: check bits above data bits
  input wire logic [CODE_W-1:0] code_i,
  // Corrected group
  output logic [DATA_W-1:0] data_o,
  output logic err_o
);
  // Hamming position of data bit j, skipping powers of two
  function automatic logic [CHK_W-1:0] pos_of(input int j);
    int c;
    begin
      pos_of = '0;
      c = 0;
      for (int p = 3; p < 64; p++) begin
        if ((p & (p - 1)) != 0) begin
          if (c == j) begin
            pos_of = p[CHK_W-1:0];
          end
          c = c + 1;
        end
      end
    end
  endfunction

  logic [CHK_W-1:0] syn;

  // ----------------------------------------------------------------
  // Syndrome and correction
  // ----------------------------------------------------------------
  // RQ14 group-wide check
  always_comb begin
    syn = code_i[CODE_W-1:DATA_W];
    for (int j = 0; j < DATA_W; j++) begin
      if (code_i[j]) begin
        syn = syn ^ pos_of(j);
      end
    end
  end

  // RQ15 flip faulty bit
  always_comb begin
    for (int j = 0; j < DATA_W; j++) begin
      data_o[j] = code_i[j] ^ (syn == pos_of(j));
    end
    err_o = (syn != '0);
  end
endmodule

// [verilog/ee_line.sv]
// Two-wire line synchroniser with edge, start and stop detection
`timescale 1ns/10ps
module ee_line
  import ee_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Raw pins
  input wire logic scl_i,
  input wire logic sda_i,
  // Conditioned events
  output logic scl_rise,
  output logic scl_fall,
  output logic start_ev,
  output logic stop_ev,
  output logic sda_lvl
);
  // ----------------------------------------------------------------
  // Synchroniser, third stage feeds edge, start and stop detection only
  // ----------------------------------------------------------------
  logic [2:0] scl_q, scl_d;
  logic [2:0] sda_q, sda_d;

  always_comb begin
    scl_d = {scl_q[1:0], scl_i};
    sda_d = {sda_q[1:0], sda_i};
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
    end
  end

  always_comb begin
    scl_rise = scl_q[1] && !scl_q[2];
    scl_fall = !scl_q[1] && scl_q[2];
    start_ev = scl_q[1] && scl_q[2] && sda_q[2] && !sda_q[1];
    stop_ev = scl_q[1] && scl_q[2] && !sda_q[2] && sda_q[1];
    sda_lvl = sda_q[1];
  end
endmodule

// [verilog/ee_lock_ecc_rd.sv]
// Two-wire slave for lock status, error status and group reads
// Behaviour
// RQ1 - Probe write acked only when sector unlocked
// RQ2 - Controller ends probe with Start then Stop
// RQ3 - Start mid-command discards the partial command
// RQ4 - Stop returns the slave to standby
// RQ5 - Select 10b in dummy write picks lock status
// RQ6 - Lock state returned in bit one
// RQ7 - Status byte repeats on every controller ack
// RQ8 - One volatile error flag for last read
// RQ9 - Select 11b in dummy write picks error status
// RQ10 - Error status byte is FFh or 00h
// RQ11 - Error flag cleared when status read ends
// RQ12 - Controller alternates group reads with status reads
// RQ13 - Corrections never signalled on the link
// RQ14 - Correction works on aligned four-byte groups
// RQ15 - Single wrong bit returned corrected
// RQ16 - Locked sector write data not acknowledged
// RQ17 - Random read uses address-only write first
// RQ18 - Flag reports the most recently read group; a read that starts mid-group keeps the old flag ORed in
`timescale 1ns/10ps
module ee_lock_ecc_rd
  import ee_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Two-wire pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Address straps
  input wire logic [2:0] addr_pin_i,
  // Nonvolatile state
  input wire logic lock_i,
  // Array read port
  output logic mem_rd,
  output logic [GRP_W-1:0] mem_grp,
  input wire logic [CODE_W-1:0] mem_code_i,
  // Status
  output logic ecc_error_flag
);
  // ----------------------------------------------------------------
  // Line conditioning and correction
  // ----------------------------------------------------------------
  logic scl_rise, scl_fall, start_ev, stop_ev, sda_lvl;
  logic [DATA_W-1:0] fix_data;
  logic fix_err;

  ee_line u_line (
    .clk(clk),
    .rstn(rstn),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_ev(start_ev),
    .stop_ev(stop_ev),
    .sda_lvl(sda_lvl)
  );

  ee_ecc u_ecc (
    .code_i(mem_code_i),
    .data_o(fix_data),
    .err_o(fix_err)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ee_st_e st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic drv_n_q, drv_n_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic spc_q, spc_d;
  logic rnw_q, rnw_d;
  logic ecc_q, ecc_d;
  logic ecc_rd_q, ecc_rd_d;
  logic mrd_q, mrd_d;
  logic [GRP_W-1:0] grp_q, grp_d;
  logic [DATA_W-1:0] cw_q, cw_d;
  logic cerr_q, cerr_d;
  logic [2:0] ap1_q, ap2_q, ap1_d, ap2_d;
  ee_rm_e rm;
  logic [7:0] byte_v;
  logic ld, lock_probe;

  // ----------------------------------------------------------------
  // Read mode and outgoing byte
  // ----------------------------------------------------------------
  // RQ5 RQ9 select decode
  always_comb begin
    if (!spc_q) begin
      rm = RM_MEM;
    end else begin
      unique case (addr_q[SEL_HI:SEL_LO])
        SEL_LOCK: rm = RM_LOCK;
        SEL_ECC: rm = RM_ECC;
        default: rm = RM_NONE;
      endcase
    end
  end

  always_comb begin
    unique case (rm)
      // RQ13 only corrected data leaves
      RM_MEM: byte_v = cw_q[addr_q[1:0]*8 +: 8];
      // RQ6 lock in bit one
      RM_LOCK: begin
        byte_v = BYTE_ZERO;
        byte_v[LOCK_FLAG_POSITION] = lock_i;
      end
      // RQ10 whole byte
      RM_ECC: byte_v = ecc_q ? ECC_BYTE_ERR : ECC_BYTE_OK;
      RM_NONE: byte_v = BYTE_IDLE;
    endcase
  end

  // Sector data writes are refused while locked
  assign lock_probe = spc_q && (addr_q[SEL_HI:SEL_LO] == SEL_SECT) && lock_i;
  assign ld = scl_fall && !start_ev && !stop_ev && (bit_q == BIT_ACK) &&
    ((st_q == ST_RDATA) || (st_q == ST_DEVA && rnw_q));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    tx_d = tx_q;
    drv_n_d = drv_n_q;
    addr_d = addr_q;
    spc_d = spc_q;
    rnw_d = rnw_q;
    ecc_d = ecc_q;
    ecc_rd_d = ecc_rd_q;
    mrd_d = 1'b0;
    grp_d = grp_q;
    cw_d = cw_q;
    cerr_d = cerr_q;
    ap1_d = addr_pin_i;
    ap2_d = ap1_q;
    if (mrd_q) begin
      cw_d = fix_data;
      cerr_d = fix_err;
    end
    if (start_ev || stop_ev) begin
      // RQ3 restart discards command
      st_d = start_ev ? ST_DEVA : ST_IDLE;
      // All ones, so the SCL fall that closes a Start wraps it to zero uncounted
      bit_d = start_ev ? ~BIT_ZERO : BIT_ZERO;
      // RQ4 release to standby
      drv_n_d = 1'b1;
      // RQ11 clear at end of status read
      if (ecc_rd_q) begin
        ecc_d = 1'b0;
        ecc_rd_d = 1'b0;
      end
    end else if (st_q != ST_IDLE && st_q != ST_HOLD) begin
      if (scl_rise) begin
        if (bit_q != BIT_ACK) begin
          sh_d = {sh_q[6:0], sda_lvl};
        end else if (st_q == ST_RDATA && sda_lvl) begin
          // RQ7 nack ends the read
          st_d = ST_HOLD;
        end
      end else if (scl_fall) begin
        if (bit_q == BIT_LAST) begin
          bit_d = BIT_ACK;
          drv_n_d = 1'b0;
          unique case (st_q)
            ST_DEVA: begin
              if ((sh_q[7:4] == DEV_CODE_MEM || sh_q[7:4] == DEV_CODE_SPC) &&
                  sh_q[3:1] == ap2_q) begin
                spc_d = (sh_q[7:4] == DEV_CODE_SPC);
                rnw_d = sh_q[0];
                mrd_d = sh_q[0];
                grp_d = addr_q[ADDR_W-1:GRP_LSB];
              end else begin
                st_d = ST_HOLD;
                drv_n_d = 1'b1;
              end
            end
            ST_ADDRH: addr_d[ADDR_W-1:8] = sh_q[ADDR_W-9:0];
            ST_ADDRL: addr_d[7:0] = sh_q;
            // RQ1 RQ16 probe answer
            ST_WDATA: drv_n_d = lock_probe;
            ST_RDATA: begin
              drv_n_d = 1'b1;
              mrd_d = 1'b1;
              grp_d = addr_q[ADDR_W-1:GRP_LSB];
            end
            default: drv_n_d = 1'b1;
          endcase
        end else if (bit_q == BIT_ACK) begin
          bit_d = BIT_ZERO;
          drv_n_d = 1'b1;
          unique case (st_q)
            ST_DEVA: st_d = rnw_q ? ST_RDATA : ST_ADDRH;
            ST_ADDRH: st_d = ST_ADDRL;
            ST_ADDRL: st_d = ST_WDATA;
            default: st_d = st_q;
          endcase
          if (ld) begin
            st_d = ST_RDATA;
            tx_d = byte_v;
            drv_n_d = byte_v[7];
            // RQ7 status bytes repeat
            if (rm == RM_MEM) begin
              addr_d = addr_q + ADDR_ONE;
              // RQ8 RQ18 flag follows group read
              if (addr_q[1:0] == BYTE_FIRST) begin
                ecc_d = cerr_q;
              end else begin
                ecc_d = ecc_q || cerr_q;
              end
            end else if (rm == RM_ECC) begin
              ecc_rd_d = 1'b1;
            end
          end
        end else begin
          bit_d = bit_q + BIT_ONE;
          if (st_q == ST_RDATA) begin
            tx_d = {tx_q[6:0], 1'b0};
            drv_n_d = tx_q[6];
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
      bit_q <= BIT_ZERO;
      sh_q <= BYTE_ZERO;
      tx_q <= BYTE_ZERO;
      drv_n_q <= 1'b1;
      addr_q <= '0;
      spc_q <= 1'b0;
      rnw_q <= 1'b0;
      ecc_q <= 1'b0;
      ecc_rd_q <= 1'b0;
      mrd_q <= 1'b0;
      grp_q <= '0;
      cw_q <= '0;
      cerr_q <= 1'b0;
      ap1_q <= 3'h0;
      ap2_q <= 3'h0;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      drv_n_q <= drv_n_d;
      addr_q <= addr_d;
      spc_q <= spc_d;
      rnw_q <= rnw_d;
      ecc_q <= ecc_d;
      ecc_rd_q <= ecc_rd_d;
      mrd_q <= mrd_d;
      grp_q <= grp_d;
      cw_q <= cw_d;
      cerr_q <= cerr_d;
      ap1_q <= ap1_d;
      ap2_q <= ap2_d;
    end
  end

  // Open drain: the pad only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_n = drv_n_q;
  assign mem_rd = mrd_q;
  assign mem_grp = grp_q;
  assign ecc_error_flag = ecc_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_START_RESETS: assert property ( // RQ3
    start_ev |=> st_q == ST_DEVA && bit_q == ~BIT_ZERO && drv_n_q)
    else $error("start did not restart protocol");
  AST_STOP_IDLE: assert property ( // RQ4
    stop_ev |=> st_q == ST_IDLE ##1 drv_n_q)
    else $error("stop did not return to standby");
  AST_LOCKED_NACK: assert property ( // RQ16
    scl_fall && !start_ev && !stop_ev && bit_q == BIT_LAST && st_q == ST_WDATA &&
    lock_probe |=> drv_n_q && bit_q == BIT_ACK)
    else $error("locked sector write was acknowledged");
  AST_UNLOCKED_ACK: assert property ( // RQ1
    scl_fall && !start_ev && !stop_ev && bit_q == BIT_LAST && st_q == ST_WDATA &&
    !lock_probe |=> !drv_n_q)
    else $error("unlocked probe not acknowledged");
  AST_LOCK_BYTE: assert property ( // RQ6
    ld && rm == RM_LOCK |=> tx_q[LOCK_FLAG_POSITION] == $past(lock_i) &&
    drv_n_q == 1'b0)
    else $error("lock status byte wrong");
  AST_ECC_BYTE: assert property ( // RQ10
    ld && rm == RM_ECC |=> tx_q == ($past(ecc_q) ? ECC_BYTE_ERR : ECC_BYTE_OK))
    else $error("error status byte wrong");
  AST_ECC_CLEAR: assert property ( // RQ11
    (start_ev || stop_ev) && ecc_rd_q |=> !ecc_q && !ecc_rd_q)
    else $error("error flag not cleared after status read");
  AST_REPEAT: assert property ( // RQ7
    ld && rm != RM_MEM |=> addr_q == $past(addr_q))
    else $error("status read moved the pointer");
  AST_GROUP_FLAG: assert property ( // RQ18
    ld && rm == RM_MEM && addr_q[1:0] == BYTE_FIRST |=> ecc_q == $past(cerr_q))
    else $error("flag does not follow last group");
  AST_FETCH: assert property ( // RQ15
    mem_rd |=> cw_q == $past(fix_data) && cerr_q == $past(fix_err))
    else $error("corrected group not captured");

  COV_LOCK_READ: cover property (ld && rm == RM_LOCK);
  COV_ECC_READ_ERR: cover property (ld && rm == RM_ECC && ecc_q);
  COV_MID_START: cover property (start_ev && st_q == ST_WDATA);
endmodule

// [verilog/ee_pkg.sv]
// Shared constants and types for the lock and error-status read block
package ee_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int GRP_W = 13;
  localparam int DATA_W = 32;
  localparam int CHK_W = 6;
  localparam int CODE_W = 38;
  // ----------------------------------------------------------------
  // Device select codes (values arbitrary)
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_CODE_MEM = 4'hA;
  localparam logic [3:0] DEV_CODE_SPC = 4'hB;
  // ----------------------------------------------------------------
  // Word address fields
  // ----------------------------------------------------------------
  localparam int SEL_HI = 10;
  localparam int SEL_LO = 9;
  localparam int GRP_LSB = 2;
  localparam logic [1:0] SEL_SECT = 2'h0;
  localparam logic [1:0] SEL_LOCK = 2'h2;
  localparam logic [1:0] SEL_ECC = 2'h3;
  localparam logic [1:0] BYTE_FIRST = 2'h0;
  localparam int LOCK_FLAG_POSITION = 1;
  // ----------------------------------------------------------------
  // Returned bytes and bit counter
  // ----------------------------------------------------------------
  localparam logic [7:0] ECC_BYTE_ERR = 8'hFF;
  localparam logic [7:0] ECC_BYTE_OK = 8'h00;
  localparam logic [7:0] BYTE_IDLE = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [14:0] ADDR_ONE = 15'h0001;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEVA, ST_ADDRH, ST_ADDRL, ST_WDATA, ST_RDATA, ST_HOLD
  } ee_st_e;
  typedef enum logic [1:0] {RM_MEM, RM_LOCK, RM_ECC, RM_NONE} ee_rm_e;
endpackage
